/* File: design/cpcu_param_command_unit.sv */
// How it works
// R1 - A write of a command byte to index 2, subindex 0 is decoded and its action carried out.
// R2 - A static command toggles on with its first write and off with the next write of it.
// R3 - Command 130 restores every parameter to its factory value.
// R4 - Command 129 returns every parameter to its default value.
// R5 - Command 160 clears the stored minimum and maximum values.
// R6 - Command 162 loads counter A from the channel A preset parameter.
// R7 - Command 163 loads counter B from the channel B preset parameter.
// R8 - Command 164 loads both counters at once, each from its own preset.
// R9 - Command 165 toggles a hold on counter A so it ignores all pulses.
// R10 - Command 166 toggles a hold on counter B so it ignores all pulses.
// R11 - Command 168 copies the current parameters into non-volatile storage.
// R12 - An unknown command value is refused and changes no parameter or counter.
`timescale 1ns/100ps
`default_nettype none

module cpcu_param_command_unit
  import cpcu_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Indexed parameter requests.
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_index,
  input wire logic [7:0] req_subindex,
  input wire logic [31:0] req_wdata,
  output logic req_ready,
  // Answers to requests.
  output logic rsp_valid,
  output logic rsp_error,
  output logic [31:0] rsp_rdata,
  // Parameters to the datapath, slot 0 in the low word.
  output logic [N_PARAMS*DATA_W-1:0] param_flat,
  // Command actions towards counters and measurement.
  output logic clear_minmax,
  output logic load_a,
  output logic load_b,
  output logic lock_a,
  output logic lock_b,
  output logic app_restart,
  // Non-volatile storage write port.
  output logic nv_wr_valid,
  output logic [15:0] nv_wr_index,
  output logic [31:0] nv_wr_data,
  input wire logic nv_wr_accept,
  output logic nv_busy
);

  // Finds the store slot of a parameter index.
  // An index outside the table gives slot 0, so callers gate it with is_param.
  function automatic logic [SLOT_W-1:0] slot_of(input logic [15:0] idx);
    logic [SLOT_W-1:0] s;
    s = '0;
    for (int i = 0; i < N_PARAMS; i++) begin
      if (PARAM_INDEX[i] == idx) begin
        s = SLOT_W'(i);
      end
    end
    return s;
  endfunction

  // Tells whether an index names a stored parameter.
  function automatic logic is_param(input logic [15:0] idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_PARAMS; i++) begin
      if (PARAM_INDEX[i] == idx) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Last slot of the store; the save ends once this word is taken.
  localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(N_PARAMS - 1);

  // Parameter store and registered outputs.
  logic [31:0] params_ff [N_PARAMS];
  logic req_ready_ff;
  logic rsp_valid_ff;
  logic rsp_error_ff;
  logic [31:0] rsp_rdata_ff;
  logic clear_minmax_ff;
  logic load_a_ff;
  logic load_b_ff;
  logic lock_a_ff;
  logic lock_b_ff;
  logic app_restart_ff;
  logic nv_wr_valid_ff;
  logic [15:0] nv_wr_index_ff;
  logic [31:0] nv_wr_data_ff;
  logic [SLOT_W-1:0] save_slot_ff;
  cpcu_save_e save_state_ff;
  logic nv_busy_ff;

  // Next values.
  cpcu_save_e nxt_save_state;
  logic [SLOT_W-1:0] nxt_save_slot;
  logic nxt_nv_wr_valid;
  logic [15:0] nxt_nv_wr_index;
  logic [31:0] nxt_nv_wr_data;

  // Request classification.
  logic take_w;
  logic hit_w;
  logic [SLOT_W-1:0] slot_w;
  logic whole_w;
  logic cmd_w;
  logic param_wr_w;
  logic param_rd_w;
  logic ok_w;
  logic defaults_w;
  logic save_start_w;

  // Decoded command flags.
  logic dec_known;
  logic dec_factory;
  logic dec_app_reset;
  logic dec_clear_minmax;
  logic dec_load_a;
  logic dec_load_b;
  logic dec_lock_a;
  logic dec_lock_b;
  logic dec_store;

  // Answer selection and action strobes for this cycle.
  logic refuse_w;
  logic [31:0] rd_word_w;
  logic clear_go_w;
  logic load_a_go_w;
  logic load_b_go_w;
  logic restart_go_w;
  logic lock_a_flip_w;
  logic lock_b_flip_w;

  // Only the low byte of the written word carries the command.
  cpcu_cmd_decode u_cmd_decode (
    .cmd_code (req_wdata[7:0]),
    .known (dec_known),
    .factory (dec_factory),
    .app_reset (dec_app_reset),
    .clear_minmax (dec_clear_minmax),
    .load_a (dec_load_a),
    .load_b (dec_load_b),
    .lock_a (dec_lock_a),
    .lock_b (dec_lock_b),
    .store (dec_store)
  );

  // A request is only taken while no save is running, so the store
  // cannot change under a half-written image.
  assign take_w = req_valid && req_ready_ff;
  assign hit_w = is_param(req_index);
  assign slot_w = slot_of(req_index);
  assign whole_w = (req_subindex == SUBIDX_WHOLE);

  // A command is a write of a known value to the command location.
  assign cmd_w = take_w && req_write && whole_w && (req_index == IDX_SYS_CMD)
               && dec_known; // R1 R12
  assign param_wr_w = take_w && req_write && whole_w && hit_w;
  assign param_rd_w = take_w && !req_write && whole_w && hit_w;
  assign ok_w = cmd_w || param_wr_w || param_rd_w;

  // Factory restore and application reset both reload the table; only
  // the factory restore also writes the fresh values to storage.
  assign defaults_w = cmd_w && (dec_factory || dec_app_reset); // R3 R4
  assign save_start_w = cmd_w && (dec_store || dec_factory); // R11 R3

  // A refused request still gets its answer, so the master never waits
  // on a request that the unit did not understand.
  assign refuse_w = take_w && !ok_w; // R12
  // The read word is picked here so the answer register stays a plain copy.
  assign rd_word_w = param_rd_w ? params_ff[slot_w] : 32'h0000_0000;

  // A decoded command becomes a strobe only on a taken command write,
  // which keeps a refused or stalled request from acting.
  assign clear_go_w = cmd_w && dec_clear_minmax; // R5
  assign load_a_go_w = cmd_w && dec_load_a; // R6 R8
  assign load_b_go_w = cmd_w && dec_load_b; // R7 R8
  assign restart_go_w = cmd_w && dec_app_reset; // R4
  assign lock_a_flip_w = cmd_w && dec_lock_a; // R2 R9
  assign lock_b_flip_w = cmd_w && dec_lock_b; // R2 R10

  // Parameter store: a defaults load beats a plain write.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_PARAMS; i++) begin
        params_ff[i] <= PARAM_RESET[i];
      end
    end else begin
      for (int i = 0; i < N_PARAMS; i++) begin
        if (defaults_w) begin
          params_ff[i] <= PARAM_RESET[i]; // R3 R4
        end else if (param_wr_w && slot_w == SLOT_W'(i)) begin
          params_ff[i] <= req_wdata;
        end
      end
    end
  end

  // Flatten the store for the datapath.
  always_comb begin
    param_flat = '0;
    for (int i = 0; i < N_PARAMS; i++) begin
      param_flat[i*DATA_W +: DATA_W] = params_ff[i];
    end
  end

  // Answer one cycle after a taken request. Reads of the write-only
  // command location and unknown commands answer with an error.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_error_ff <= 1'b0;
      rsp_rdata_ff <= 32'h0000_0000;
    end else begin
      rsp_valid_ff <= take_w;
      rsp_error_ff <= refuse_w; // R12
      rsp_rdata_ff <= rd_word_w;
    end
  end

  // One-cycle action pulses; the combined load drives both.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clear_minmax_ff <= 1'b0;
      load_a_ff <= 1'b0;
      load_b_ff <= 1'b0;
      app_restart_ff <= 1'b0;
    end else begin
      clear_minmax_ff <= clear_go_w; // R5
      load_a_ff <= load_a_go_w; // R6 R8
      load_b_ff <= load_b_go_w; // R7 R8
      app_restart_ff <= restart_go_w; // R4
    end
  end

  // Counter holds toggle on each write of their command. They are not
  // parameters, so a defaults load leaves them as they are.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_a_ff <= 1'b0;
      lock_b_ff <= 1'b0;
    end else begin
      lock_a_ff <= lock_a_ff ^ lock_a_flip_w; // R2 R9
      lock_b_ff <= lock_b_ff ^ lock_b_flip_w; // R2 R10
    end
  end

  // Saving sequencer: LOAD fetches one word, SEND offers it until the
  // storage takes it. Each word costs at least two cycles, which keeps
  // the data path a plain register instead of a read-ahead buffer.
  always_comb begin
    nxt_save_state = save_state_ff;
    nxt_save_slot = save_slot_ff;
    nxt_nv_wr_valid = nv_wr_valid_ff;
    nxt_nv_wr_index = nv_wr_index_ff;
    nxt_nv_wr_data = nv_wr_data_ff;
    case (save_state_ff)
      CPCU_IDLE: begin
        if (save_start_w) begin
          nxt_save_state = CPCU_LOAD; // R11
          nxt_save_slot = '0;
        end
      end
      CPCU_LOAD: begin
        nxt_nv_wr_valid = 1'b1;
        nxt_nv_wr_index = PARAM_INDEX[save_slot_ff];
        nxt_nv_wr_data = params_ff[save_slot_ff];
        nxt_save_state = CPCU_SEND;
      end
      CPCU_SEND: begin
        if (nv_wr_accept) begin
          nxt_nv_wr_valid = 1'b0;
          if (save_slot_ff == LAST_SLOT) begin
            nxt_save_state = CPCU_IDLE;
          end else begin
            nxt_save_slot = save_slot_ff + 1'b1;
            nxt_save_state = CPCU_LOAD;
          end
        end
      end
      default: begin
        nxt_save_state = CPCU_IDLE;
        nxt_nv_wr_valid = 1'b0;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      save_state_ff <= CPCU_IDLE;
      save_slot_ff <= '0;
      nv_wr_valid_ff <= 1'b0;
      nv_wr_index_ff <= 16'h0000;
      nv_wr_data_ff <= 32'h0000_0000;
    end else begin
      save_state_ff <= nxt_save_state;
      save_slot_ff <= nxt_save_slot;
      nv_wr_valid_ff <= nxt_nv_wr_valid;
      nv_wr_index_ff <= nxt_nv_wr_index;
      nv_wr_data_ff <= nxt_nv_wr_data;
    end
  end

  // Ready falls in the same edge that starts a save and rises with the
  // edge that takes the last word.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_ready_ff <= 1'b1;
    end else begin
      req_ready_ff <= (nxt_save_state == CPCU_IDLE);
    end
  end

  // Busy has a register of its own so the port comes straight from a
  // flop; it always reads as the inverse of ready.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nv_busy_ff <= 1'b0;
    end else begin
      nv_busy_ff <= (nxt_save_state != CPCU_IDLE); // R11
    end
  end

  // Ports.
  assign req_ready = req_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_error = rsp_error_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign clear_minmax = clear_minmax_ff;
  assign load_a = load_a_ff;
  assign load_b = load_b_ff;
  assign lock_a = lock_a_ff;
  assign lock_b = lock_b_ff;
  assign app_restart = app_restart_ff;
  assign nv_wr_valid = nv_wr_valid_ff;
  assign nv_wr_index = nv_wr_index_ff;
  assign nv_wr_data = nv_wr_data_ff;
  assign nv_busy = nv_busy_ff;

endmodule // cpcu_param_command_unit

`default_nettype wire

/* File: design/cpcu_pkg.sv */
package cpcu_pkg;

  // Shape of the parameter store.
  localparam int N_PARAMS = 22;
  localparam int SLOT_W = 5;
  localparam int DATA_W = 32;

  // Location of the system command.
  localparam logic [15:0] IDX_SYS_CMD = 16'h0002;
  localparam logic [7:0] SUBIDX_WHOLE = 8'h00;

  // Parameter indices.
  localparam logic [15:0] IDX_FREQ_MEASURE_SELECT = 16'h0102;
  localparam logic [15:0] IDX_FREQ_UNIT_BASE = 16'h0103;
  localparam logic [15:0] IDX_GATE_PERIOD_ONE = 16'h0104;
  localparam logic [15:0] IDX_ZERO_TIMEOUT_ONE = 16'h0105;
  localparam logic [15:0] IDX_SMOOTHING_DEPTH_ONE = 16'h0106;
  localparam logic [15:0] IDX_GATE_PERIOD_TWO = 16'h0107;
  localparam logic [15:0] IDX_ZERO_TIMEOUT_TWO = 16'h0108;
  localparam logic [15:0] IDX_SMOOTHING_DEPTH_TWO = 16'h0109;
  localparam logic [15:0] IDX_PULSE_COUNT_SELECT = 16'h010d;
  localparam logic [15:0] IDX_SCALE_A = 16'h010e;
  localparam logic [15:0] IDX_PRESET_A = 16'h010f;
  localparam logic [15:0] IDX_SCALE_B = 16'h0110;
  localparam logic [15:0] IDX_PRESET_B = 16'h0111;
  localparam logic [15:0] IDX_WRAP_MODULUS = 16'h0112;
  localparam logic [15:0] IDX_FUNCTION_SELECT = 16'h0116;
  localparam logic [15:0] IDX_INPUT_TYPE_SELECT = 16'h0117;
  localparam logic [15:0] IDX_COUNT_SENSE = 16'h0118;
  localparam logic [15:0] IDX_RETAIN_ON_POWERDOWN = 16'h0119;
  localparam logic [15:0] IDX_THRESHOLD_LOW = 16'h011a;
  localparam logic [15:0] IDX_THRESHOLD_HIGH = 16'h011b;
  localparam logic [15:0] IDX_DIAG_ENABLE_MASK = 16'h011c;
  localparam logic [15:0] IDX_OUTPUT_ORIGIN = 16'h011d;

  // Default and factory values.
  localparam logic [31:0] RST_FREQ_MEASURE_SELECT = 32'h0000_0000;
  localparam logic [31:0] RST_FREQ_UNIT_BASE = 32'h0000_0001;
  localparam logic [31:0] RST_GATE_PERIOD_ONE = 32'h0000_0001;
  localparam logic [31:0] RST_ZERO_TIMEOUT_ONE = 32'h0000_0064;
  localparam logic [31:0] RST_SMOOTHING_DEPTH_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_GATE_PERIOD_TWO = 32'h0000_0001;
  localparam logic [31:0] RST_ZERO_TIMEOUT_TWO = 32'h0000_0064;
  localparam logic [31:0] RST_SMOOTHING_DEPTH_TWO = 32'h0000_0000;
  localparam logic [31:0] RST_PULSE_COUNT_SELECT = 32'h0000_0003;
  localparam logic [31:0] RST_SCALE_A = 32'h0001_86a0;
  localparam logic [31:0] RST_PRESET_A = 32'h0000_0000;
  localparam logic [31:0] RST_SCALE_B = 32'h0001_86a0;
  localparam logic [31:0] RST_PRESET_B = 32'h0000_0000;
  localparam logic [31:0] RST_WRAP_MODULUS = 32'h0000_0000;
  localparam logic [31:0] RST_FUNCTION_SELECT = 32'h0000_0000;
  localparam logic [31:0] RST_INPUT_TYPE_SELECT = 32'h0000_0000;
  localparam logic [31:0] RST_COUNT_SENSE = 32'h0000_0000;
  localparam logic [31:0] RST_RETAIN_ON_POWERDOWN = 32'h0000_0001;
  localparam logic [31:0] RST_THRESHOLD_LOW = 32'h0000_0000;
  localparam logic [31:0] RST_THRESHOLD_HIGH = 32'h3b9a_c9ff;
  localparam logic [31:0] RST_DIAG_ENABLE_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_OUTPUT_ORIGIN = 32'h0000_0000;

  // Slot order of the store, shared by lookup, reset and saving.
  localparam logic [15:0] PARAM_INDEX [N_PARAMS] = '{
    IDX_FREQ_MEASURE_SELECT, IDX_FREQ_UNIT_BASE, IDX_GATE_PERIOD_ONE,
    IDX_ZERO_TIMEOUT_ONE, IDX_SMOOTHING_DEPTH_ONE, IDX_GATE_PERIOD_TWO,
    IDX_ZERO_TIMEOUT_TWO, IDX_SMOOTHING_DEPTH_TWO, IDX_PULSE_COUNT_SELECT,
    IDX_SCALE_A, IDX_PRESET_A, IDX_SCALE_B, IDX_PRESET_B, IDX_WRAP_MODULUS,
    IDX_FUNCTION_SELECT, IDX_INPUT_TYPE_SELECT, IDX_COUNT_SENSE,
    IDX_RETAIN_ON_POWERDOWN, IDX_THRESHOLD_LOW, IDX_THRESHOLD_HIGH,
    IDX_DIAG_ENABLE_MASK, IDX_OUTPUT_ORIGIN};
  localparam logic [31:0] PARAM_RESET [N_PARAMS] = '{
    RST_FREQ_MEASURE_SELECT, RST_FREQ_UNIT_BASE, RST_GATE_PERIOD_ONE,
    RST_ZERO_TIMEOUT_ONE, RST_SMOOTHING_DEPTH_ONE, RST_GATE_PERIOD_TWO,
    RST_ZERO_TIMEOUT_TWO, RST_SMOOTHING_DEPTH_TWO, RST_PULSE_COUNT_SELECT,
    RST_SCALE_A, RST_PRESET_A, RST_SCALE_B, RST_PRESET_B, RST_WRAP_MODULUS,
    RST_FUNCTION_SELECT, RST_INPUT_TYPE_SELECT, RST_COUNT_SENSE,
    RST_RETAIN_ON_POWERDOWN, RST_THRESHOLD_LOW, RST_THRESHOLD_HIGH,
    RST_DIAG_ENABLE_MASK, RST_OUTPUT_ORIGIN};

  // System command values.
  localparam logic [7:0] CMD_APP_RESET = 8'h81;
  localparam logic [7:0] CMD_FACTORY = 8'h82;
  localparam logic [7:0] CMD_CLEAR_MINMAX = 8'ha0;
  localparam logic [7:0] CMD_LOAD_A = 8'ha2;
  localparam logic [7:0] CMD_LOAD_B = 8'ha3;
  localparam logic [7:0] CMD_LOAD_BOTH = 8'ha4;
  localparam logic [7:0] CMD_LOCK_A = 8'ha5;
  localparam logic [7:0] CMD_LOCK_B = 8'ha6;
  localparam logic [7:0] CMD_STORE = 8'ha8;

  // Saving sequencer states.
  typedef enum logic [1:0] {
    CPCU_IDLE = 2'b00,
    CPCU_LOAD = 2'b01,
    CPCU_SEND = 2'b10
  } cpcu_save_e;

endpackage

/* File: design/cpcu_cmd_decode.sv */
`timescale 1ns/100ps
`default_nettype none

// Turns a command byte into one flag per action.
module cpcu_cmd_decode
  import cpcu_pkg::*;
(
  // Command byte.
  input wire logic [7:0] cmd_code,
  // Decoded actions.
  output logic known,
  output logic factory,
  output logic app_reset,
  output logic clear_minmax,
  output logic load_a,
  output logic load_b,
  output logic lock_a,
  output logic lock_b,
  output logic store
);

  // The combined load counts as a load of each channel.
  assign factory = (cmd_code == CMD_FACTORY); // R3
  assign app_reset = (cmd_code == CMD_APP_RESET); // R4
  assign clear_minmax = (cmd_code == CMD_CLEAR_MINMAX); // R5
  assign load_a = (cmd_code == CMD_LOAD_A) || (cmd_code == CMD_LOAD_BOTH); // R6
  assign load_b = (cmd_code == CMD_LOAD_B) || (cmd_code == CMD_LOAD_BOTH); // R7
  assign lock_a = (cmd_code == CMD_LOCK_A); // R9
  assign lock_b = (cmd_code == CMD_LOCK_B); // R10
  assign store = (cmd_code == CMD_STORE); // R11

  // Anything else is not a command at all.
  assign known = factory | app_reset | clear_minmax | load_a | load_b
               | lock_a | lock_b | store; // R12

endmodule // cpcu_cmd_decode

`default_nettype wire

/* File: verification/cpcu_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the command unit.
module cpcu_chk
  import cpcu_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Requests and answers.
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_index,
  input wire logic [7:0] req_subindex,
  input wire logic [31:0] req_wdata,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [31:0] rsp_rdata,
  // Parameters and actions.
  input wire logic [N_PARAMS*DATA_W-1:0] param_flat,
  input wire logic clear_minmax,
  input wire logic load_a,
  input wire logic load_b,
  input wire logic lock_a,
  input wire logic lock_b,
  input wire logic app_restart,
  // Storage port.
  input wire logic nv_wr_valid,
  input wire logic [15:0] nv_wr_index,
  input wire logic [31:0] nv_wr_data,
  input wire logic nv_wr_accept,
  input wire logic nv_busy
);
  // A command write taken at this edge, and whether its code is one we act on.
  wire logic cmd_wr = req_valid && req_ready && req_write && req_index == IDX_SYS_CMD
    && req_subindex == SUBIDX_WHOLE;
  wire logic [7:0] code = req_wdata[7:0];
  wire logic known = code inside {CMD_APP_RESET, CMD_FACTORY, CMD_CLEAR_MINMAX, CMD_LOAD_A,
    CMD_LOAD_B, CMD_LOAD_BOTH, CMD_LOCK_A, CMD_LOCK_B, CMD_STORE};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  answer_follows_a: assert property (req_valid && req_ready |=> rsp_valid)
    else $error("missing answer");
  no_stray_answer_a: assert property (!(req_valid && req_ready) |=> !rsp_valid)
    else $error("stray answer");
  lock_a_toggle_a: assert property (cmd_wr && code == CMD_LOCK_A |=> lock_a != $past(lock_a))
    else $error("lock a did not toggle");
  lock_b_hold_a: assert property (!(cmd_wr && code == CMD_LOCK_B) |=> $stable(lock_b))
    else $error("lock b moved");
  load_both_a: assert property (cmd_wr && code == CMD_LOAD_BOTH |=> load_a && load_b)
    else $error("load both missing");
  load_one_a: assert property (cmd_wr && code == CMD_LOAD_A |=> load_a && !load_b)
    else $error("load a wrong");
  clear_pulse_a: assert property (cmd_wr && code == CMD_CLEAR_MINMAX |=> clear_minmax)
    else $error("clear missing");
  app_reset_a: assert property (cmd_wr && code == CMD_APP_RESET |=> app_restart
    && param_flat[9*DATA_W +: DATA_W] == RST_SCALE_A) else $error("app reset wrong");
  factory_load_a: assert property (cmd_wr && code == CMD_FACTORY |=> !app_restart
    && !req_ready && param_flat[10*DATA_W +: DATA_W] == RST_PRESET_A) else $error("factory wrong");
  unknown_cmd_a: assert property (cmd_wr && !known |=> rsp_error && $stable(param_flat)
    && !load_a && !load_b) else $error("unknown command acted");
  save_start_a: assert property (cmd_wr && code == CMD_STORE |=> !req_ready ##[1:2]
    (nv_wr_valid && nv_wr_index == IDX_FREQ_MEASURE_SELECT)) else $error("save start wrong");
  offer_holds_a: assert property (nv_wr_valid && !nv_wr_accept |=> nv_wr_valid
    && $stable(nv_wr_index) && $stable(nv_wr_data)) else $error("offer dropped");

  lock_seen_c: cover property ($rose(lock_a));
  word_saved_c: cover property (nv_wr_valid && !nv_wr_accept ##1 nv_wr_accept);
  refused_c: cover property (rsp_valid && rsp_error);
endmodule // cpcu_chk

bind cpcu_param_command_unit cpcu_chk u_chk (.*);
`default_nettype wire

/* File: verification/cpcu_nv_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Behavioural non-volatile store; a slow store stretches a save at random.
module cpcu_nv_model
  import cpcu_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Offered word and stall control.
  input wire logic nv_wr_valid,
  input wire logic [15:0] nv_wr_index,
  input wire logic [31:0] nv_wr_data,
  input wire logic slow,
  output var logic nv_wr_accept
);
  // Committed words, oldest first.
  logic [15:0] got_idx [$];
  logic [31:0] got_dat [$];
  int seed = 32'h58dc;

  // A word counts only at an edge where it is offered and accepted together.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nv_wr_accept <= 1'b0;
    end else begin
      if (nv_wr_valid && nv_wr_accept) begin
        got_idx.push_back(nv_wr_index);
        got_dat.push_back(nv_wr_data);
      end
      nv_wr_accept <= slow ? 1'($random(seed)) : 1'b1;
    end
  end
endmodule // cpcu_nv_model
`default_nettype wire

/* File: verification/cpcu_param_command_unit_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Drives indexed requests and compares every answer with a reference model.
module cpcu_param_command_unit_tb_top
  import cpcu_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [15:0] req_index = 16'h0000;
  logic [7:0] req_subindex = 8'h00;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic req_ready, rsp_valid, rsp_error, clear_minmax, load_a, load_b, lock_a, lock_b;
  logic app_restart, nv_wr_valid, nv_wr_accept, nv_busy;
  logic slow = 1'b0;
  logic [31:0] rsp_rdata, nv_wr_data, r;
  logic [15:0] nv_wr_index;
  logic [N_PARAMS*DATA_W-1:0] param_flat;
  // Reference model: parameter values and the two counter holds.
  logic [31:0] mdl [N_PARAMS];
  logic lk_a, lk_b;
  logic [7:0] cmds [15] = '{8'ha0, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha5, 8'ha6, 8'ha5, 8'h7f,
    8'h81, 8'ha8, 8'h82, 8'ha6, 8'h00, 8'hff};
  int err_total = 0;
  int checks_done = 0;
  int seed = 32'h58dc;

  always #12.5 ref_clk = ~ref_clk;

  cpcu_param_command_unit DUT (.*);
  cpcu_nv_model u_nv (.*);

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic mdl_reset();
    foreach (mdl[k]) mdl[k] = PARAM_RESET[k];
  endtask

  // One request: the model predicts first, then the design's answer is compared.
  task automatic xfer(logic wr, logic [15:0] idx, logic [7:0] sub, logic [31:0] d);
    int n;
    int slot;
    logic err;
    logic save;
    logic [31:0] rd;
    logic [3:0] act;
    n = 0;
    slot = -1;
    err = 1'b0;
    save = 1'b0;
    rd = 32'h0000_0000;
    act = 4'h0;
    foreach (PARAM_INDEX[k]) if (PARAM_INDEX[k] == idx) slot = k;
    if (sub != SUBIDX_WHOLE || (idx != IDX_SYS_CMD && slot < 0) || (idx == IDX_SYS_CMD && !wr)) begin
      err = 1'b1;
    end else if (idx == IDX_SYS_CMD) begin
      case (d[7:0])
        CMD_APP_RESET: begin mdl_reset(); act[0] = 1'b1; end
        CMD_FACTORY: begin mdl_reset(); save = 1'b1; end
        CMD_CLEAR_MINMAX: act[3] = 1'b1;
        CMD_LOAD_A: act[2] = 1'b1;
        CMD_LOAD_B: act[1] = 1'b1;
        CMD_LOAD_BOTH: act[2:1] = 2'b11;
        CMD_LOCK_A: lk_a = !lk_a;
        CMD_LOCK_B: lk_b = !lk_b;
        CMD_STORE: save = 1'b1;
        default: err = 1'b1;
      endcase
    end else if (wr) begin
      mdl[slot] = d;
    end else begin
      rd = mdl[slot];
    end
    while (req_ready !== 1'b1 && n < 2000) begin @(negedge ref_clk); n++; end
    if (n >= 2000) err_total++;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_index <= idx;
    req_subindex <= sub;
    req_wdata <= d;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    cmp(32'(rsp_valid), 32'h1);
    cmp(32'(rsp_error), 32'(err));
    cmp(rsp_rdata, rd);
    cmp(32'({clear_minmax, load_a, load_b, lock_a, lock_b, app_restart}),
        32'({act[3:1], lk_a, lk_b, act[0]}));
    cmp(32'({req_ready, nv_busy}), save ? 32'h1 : 32'h2);
    foreach (mdl[k]) cmp(param_flat[k*DATA_W +: DATA_W], mdl[k]);
    if (save) begin
      while (req_ready !== 1'b1 && n < 4000) begin @(negedge ref_clk); n++; end
      if (n >= 4000) err_total++;
      cmp(32'(nv_busy), 32'h0);
      cmp(32'(u_nv.got_idx.size()), 32'(N_PARAMS));
      foreach (mdl[k]) cmp({16'h0, u_nv.got_idx[k]}, {16'h0, PARAM_INDEX[k]});
      foreach (mdl[k]) cmp(u_nv.got_dat[k], mdl[k]);
      u_nv.got_idx.delete();
      u_nv.got_dat.delete();
    end
  endtask

  // Main sequence; a second reset in mid-run must bring back the defaults.
  initial begin
    mdl_reset();
    lk_a = 1'b0;
    lk_b = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (PARAM_INDEX[k]) xfer(1'b0, PARAM_INDEX[k], 8'h00, 32'h0);
    foreach (PARAM_INDEX[k]) xfer(1'b1, PARAM_INDEX[k], 8'h00, $random(seed));
    foreach (PARAM_INDEX[k]) xfer(1'b0, PARAM_INDEX[k], 8'h00, 32'h0);
    xfer(1'b0, IDX_SYS_CMD, 8'h00, 32'h0000_00a5);
    xfer(1'b1, 16'h0100, 8'h00, 32'h0000_0001);
    xfer(1'b1, IDX_PRESET_A, 8'h01, 32'h0000_0007);
    foreach (cmds[k]) begin
      slow = k[0];
      xfer(1'b1, IDX_SYS_CMD, 8'h00, {24'($random(seed)), cmds[k]});
    end
    repeat (300) begin
      r = $random(seed);
      if (r[1:0] == 2'b00) begin
        xfer(1'b1, IDX_SYS_CMD, 8'h00, {r[31:8], cmds[r[7:4] % 15]});
      end else begin
        xfer(r[2], PARAM_INDEX[r[12:8] % N_PARAMS], {7'h0, r[14:13] == 2'b11}, $random(seed));
      end
    end
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    mdl_reset();
    lk_a = 1'b0;
    lk_b = 1'b0;
    foreach (PARAM_INDEX[k]) xfer(1'b0, PARAM_INDEX[k], 8'h00, 32'h0);
    finish_test();
  end

  // Watchdog well beyond the expected few thousand cycles.
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
endmodule // cpcu_param_command_unit_tb_top
`default_nettype wire
